// ---- rtl/pss_pkg.sv ----
`default_nettype none
package pss_pkg;
   // Register byte offsets on the AHB-Lite bus
   localparam logic [7:0]  ADDR_ENABLE  = 8'h00;
   localparam logic [7:0]  ADDR_ITIME   = 8'h08;
   localparam logic [7:0]  ADDR_WTIME   = 8'h0C;
   localparam logic [7:0]  ADDR_PULSE   = 8'h38;
   localparam logic [7:0]  ADDR_CONFIG  = 8'h3C;
   localparam logic [7:0]  ADDR_RESULT  = 8'h60;
   localparam logic [7:0]  ADDR_ADCIN   = 8'h64;
   localparam logic [7:0]  ADDR_STATUS  = 8'h68;
   // Enable register fields
   localparam int          EN_PWR       = 0;
   localparam int          EN_PROX      = 2;
   localparam int          EN_WAIT      = 3;
   // Config register fields
   localparam int          CFG_LONG     = 1;
   localparam int          CFG_DIODE_LO = 4;
   localparam int          CFG_DRIVE_LO = 6;
   // Reset values
   localparam logic [7:0]  RST_ENABLE   = 8'h00;
   localparam logic [7:0]  RST_ITIME    = 8'hFF;
   localparam logic [7:0]  RST_WTIME    = 8'hFF;
   localparam logic [7:0]  RST_PULSE    = 8'h01;
   localparam logic [7:0]  RST_CONFIG   = 8'h00;
   // Timing at the 50 MHz bus clock
   localparam int          CLK_MHZ      = 50;
   localparam int          PULSE_NS     = 16000;
   localparam int          LED_ON_NS    = 7200;
   localparam int          STEP_US      = 2720;
   localparam int          PULSE_CYC    = PULSE_NS * CLK_MHZ / 1000;
   localparam int          LED_ON_CYC   = LED_ON_NS * CLK_MHZ / 1000;
   localparam int          STEP_CYC     = STEP_US * CLK_MHZ;
   localparam int          LONG_MULT    = 12;
   localparam logic [1:0]  HTRANS_NSEQ  = 2'b10;
   typedef enum logic [2:0] {
      PSS_SLEEP = 3'b000,
      PSS_START = 3'b001,
      PSS_ACCUM = 3'b011,
      PSS_CONV  = 3'b010,
      PSS_WAIT  = 3'b110
   } pss_state_t;
endpackage : pss_pkg
`default_nettype wire

// ---- rtl/pss_step_timer.sv ----
`default_nettype none
// Counts a number of fixed-length steps, each optionally stretched
module pss_step_timer #(
   parameter int STEP_CYCLES = 136000
) (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       start,
   input  wire logic [8:0] steps,
   input  wire logic [3:0] mult,
   output logic            done
);
   logic [31:0] cyc;
   logic [8:0]  step_left;
   logic [3:0]  sub_left;
   logic [3:0]  mult_q;
   logic        busy;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cyc       <= 32'h0000_0000;
         step_left <= 9'h000;
         sub_left  <= 4'h0;
         mult_q    <= 4'h0;
         busy      <= 1'b0;
         done      <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            busy      <= 1'b1;
            cyc       <= 32'(STEP_CYCLES - 1);
            step_left <= steps;
            sub_left  <= mult;
            // Held so every step, not just the first, keeps the stretch
            mult_q    <= mult;
         end else if (busy) begin
            if (cyc != 32'h0000_0000) begin
               cyc <= cyc - 32'h0000_0001;
            end else begin
               cyc <= 32'(STEP_CYCLES - 1);
               if (sub_left > 4'h1) begin
                  sub_left <= sub_left - 4'h1;
               end else begin
                  sub_left <= mult_q;
                  if (step_left > 9'h001) begin
                     step_left <= step_left - 9'h001;
                  end else begin
                     busy <= 1'b0;
                     done <= 1'b1;
                  end
               end
            end
         end
      end
   end
endmodule : pss_step_timer
`default_nettype wire

// ---- rtl/pss_sequencer.sv ----
// Implementation choices: the AHB-Lite register port and the register addresses.
`default_nettype none
// Summary of operation
// - After reset stay asleep until power-on set
// - Power-on set moves sleep to start
// - Start, proximity, wait; skip disabled states
// - Power-off finishes running conversion, then sleeps
// - Power-on is bit 0 of enable register
// - Diode select: none, infrared, broadband, both
// - Latch conversion result at integration end
// - LED current: 12.5, 25, 50, 100 mA
// - One to 255 pulses, 16 us each
// - Proximity is pulse accumulation then conversion
// - Wait enable spends programmed wait time
// - Long wait stretches each step twelvefold
module pss_sequencer #(
   parameter int STEP_CYCLES = pss_pkg::STEP_CYC
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [9:0]  adc_sample,
   output logic             led_sink_pin,
   output logic [1:0]       led_current_setting,
   output logic [1:0]       photodiode_select,
   output logic             adc_busy,
   output logic             sleeping
);
   import pss_pkg::*;

   logic [7:0]  enable_reg;
   logic [7:0]  integration_time_setting;
   logic [7:0]  wait_time_setting;
   logic [7:0]  pulse_count_setting;
   logic [7:0]  config_reg;
   logic [15:0] proximity_result;
   logic [7:0]  wr_addr;
   logic        wr_pend;
   pss_state_t  state;
   logic [15:0] pulse_cyc;
   logic [7:0]  pulses_left;
   logic [15:0] accum;
   logic        tmr_start;
   logic [8:0]  tmr_steps;
   logic [3:0]  tmr_mult;
   logic        tmr_done;
   logic        power_on_bit;
   logic        prox_enable_bit;
   logic        wait_enable_bit;
   logic        long_wait_bit;
   logic        rd_go;

   assign power_on_bit    = enable_reg[EN_PWR];
   assign prox_enable_bit = enable_reg[EN_PROX];
   assign wait_enable_bit = enable_reg[EN_WAIT];
   assign long_wait_bit   = config_reg[CFG_LONG];
   assign rd_go = hsel && hready && htrans == HTRANS_NSEQ && !hwrite;

   // Zero-wait slave, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend   <= 1'b0;
         wr_addr   <= 8'h00;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (hready) begin
            wr_pend <= hsel && htrans == HTRANS_NSEQ && hwrite;
            wr_addr <= haddr[7:0];
         end
      end
   end

   // Register writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enable_reg               <= RST_ENABLE;
         integration_time_setting <= RST_ITIME;
         wait_time_setting        <= RST_WTIME;
         pulse_count_setting      <= RST_PULSE;
         config_reg               <= RST_CONFIG;
      end else if (wr_pend) begin
         unique case (wr_addr)
            ADDR_ENABLE: enable_reg <= hwdata[7:0];
            ADDR_ITIME:  integration_time_setting <= hwdata[7:0];
            ADDR_WTIME:  wait_time_setting <= hwdata[7:0];
            ADDR_PULSE: begin
               // Zero would give no pulses; held at the least of one
               pulse_count_setting <= (hwdata[7:0] == 8'h00) ?
                                      8'h01 : hwdata[7:0];
            end
            ADDR_CONFIG: config_reg <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   // Register reads, unmapped addresses read zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_go) begin
         unique case (haddr[7:0])
            ADDR_ENABLE: hrdata <= {24'h00_0000, enable_reg};
            ADDR_ITIME:  hrdata <= {24'h00_0000, integration_time_setting};
            ADDR_WTIME:  hrdata <= {24'h00_0000, wait_time_setting};
            ADDR_PULSE:  hrdata <= {24'h00_0000, pulse_count_setting};
            ADDR_CONFIG: hrdata <= {24'h00_0000, config_reg};
            ADDR_RESULT: hrdata <= {16'h0000, proximity_result};
            ADDR_STATUS: hrdata <= {29'h0000_0000, 3'(state)};
            default:     hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // Step counts are 256 minus the setting, as with the wait time
   always_comb begin
      tmr_start = 1'b0;
      tmr_steps = 9'h100 - {1'b0, wait_time_setting};
      tmr_mult  = 4'h1;
      // The last pulse reloads its counter, so the count alone ends it
      if (state == PSS_ACCUM && pulses_left == 8'h00) begin
         tmr_start = 1'b1;
         tmr_steps = 9'h100 - {1'b0, integration_time_setting};
      end else if (state == PSS_START && !prox_enable_bit &&
                   wait_enable_bit) begin
         tmr_start = 1'b1;
         tmr_mult  = long_wait_bit ? 4'(LONG_MULT) : 4'h1;
      end else if (state == PSS_CONV && tmr_done && wait_enable_bit &&
                   power_on_bit) begin
         tmr_start = 1'b1;
         tmr_mult  = long_wait_bit ? 4'(LONG_MULT) : 4'h1;
      end
   end

   pss_step_timer #(
      .STEP_CYCLES (STEP_CYCLES)
   ) u_timer (
      .hclk    (hclk),
      .hresetn (hresetn),
      .start   (tmr_start),
      .steps   (tmr_steps),
      .mult    (tmr_mult),
      .done    (tmr_done)
   );

   // Sequencer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= PSS_SLEEP;
      end else begin
         unique case (state)
            PSS_SLEEP: if (power_on_bit) state <= PSS_START;
            PSS_START: begin
               if (!power_on_bit) begin
                  state <= PSS_SLEEP;
               end else if (prox_enable_bit) begin
                  state <= PSS_ACCUM;
               end else if (wait_enable_bit) begin
                  state <= PSS_WAIT;
               end
            end
            PSS_ACCUM: begin
               if (tmr_start) state <= PSS_CONV;
            end
            PSS_CONV: begin
               // Power-off is only honoured once the conversion ends
               if (tmr_done) begin
                  if (!power_on_bit) begin
                     state <= PSS_SLEEP;
                  end else if (wait_enable_bit) begin
                     state <= PSS_WAIT;
                  end else begin
                     state <= PSS_START;
                  end
               end
            end
            PSS_WAIT: begin
               if (!power_on_bit) state <= PSS_SLEEP;
               else if (tmr_done) state <= PSS_START;
            end
            default: state <= PSS_SLEEP;
         endcase
      end
   end

   // LED pulse train and accumulation
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pulse_cyc    <= 16'h0000;
         pulses_left  <= 8'h00;
         led_sink_pin <= 1'b0;
         accum        <= 16'h0000;
      end else if (state == PSS_START) begin
         pulses_left  <= pulse_count_setting;
         pulse_cyc    <= 16'(PULSE_CYC - 1);
         accum        <= 16'h0000;
         led_sink_pin <= 1'b0;
      end else if (state == PSS_ACCUM && pulses_left != 8'h00) begin
         led_sink_pin <= pulse_cyc > 16'(PULSE_CYC - 1 - LED_ON_CYC);
         if (pulse_cyc == 16'h0000) begin
            pulse_cyc   <= 16'(PULSE_CYC - 1);
            pulses_left <= pulses_left - 8'h01;
            // Sample accumulates once per pulse
            accum <= accum + {6'h00, adc_sample};
         end else begin
            pulse_cyc <= pulse_cyc - 16'h0001;
         end
      end else begin
         led_sink_pin <= 1'b0;
      end
   end

   // Result latch and status outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         proximity_result    <= 16'h0000;
         led_current_setting <= 2'b00;
         photodiode_select   <= 2'b00;
         adc_busy            <= 1'b0;
         sleeping            <= 1'b1;
      end else begin
         if (state == PSS_CONV && tmr_done) begin
            proximity_result <= accum;
         end
         led_current_setting <= config_reg[CFG_DRIVE_LO +: 2];
         photodiode_select   <= config_reg[CFG_DIODE_LO +: 2];
         adc_busy            <= state == PSS_ACCUM || state == PSS_CONV;
         sleeping            <= state == PSS_SLEEP;
      end
   end
endmodule : pss_sequencer
`default_nettype wire

// ---- verification/pss_afe_model.sv ----
`default_nettype none
// Front-end stand-in: fixed count while measuring, churn otherwise
module pss_afe_model #(
   parameter logic [9:0] SAMPLE = 10'h0A5
) (
   input  wire logic       hclk,
   input  wire logic       adc_busy,
   output logic [9:0]      adc_sample
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] junk = 10'h155;
   // Toggles so an idle-time sample never looks like a real count
   always @(posedge hclk) junk <= ~junk;
   assign adc_sample = adc_busy ? SAMPLE : junk;
endmodule : pss_afe_model
`default_nettype wire

// ---- verification/pss_props.sv ----
`default_nettype none
module pss_props #(
   parameter int STEP_CYCLES = 20
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        led_sink_pin,
   input wire logic [1:0]  led_current_setting,
   input wire logic [1:0]  photodiode_select,
   input wire logic        adc_busy,
   input wire logic        sleeping
);
   import pss_pkg::*;
   logic       wr_en, wr_cfg, cfg_q, rd_adc, pwr_q;
   logic [1:0] drv_e, dio_e;
   logic [9:0] on_cnt;
   wire logic  take = hsel && hready && htrans == HTRANS_NSEQ;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_en  <= 1'b0;
         wr_cfg <= 1'b0;
         rd_adc <= 1'b0;
      end else begin
         wr_en  <= take && hwrite && haddr[7:0] == ADDR_ENABLE;
         wr_cfg <= take && hwrite && haddr[7:0] == ADDR_CONFIG;
         rd_adc <= take && !hwrite && haddr[7:0] == ADDR_ADCIN;
      end
   end
   // Mirror of the power-on bit, landing with the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) pwr_q <= 1'b0;
      else if (wr_en) pwr_q <= hwdata[EN_PWR];
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_q <= 1'b0;
         drv_e <= 2'b00;
         dio_e <= 2'b00;
      end else begin
         cfg_q <= wr_cfg;
         if (wr_cfg) begin
            drv_e <= hwdata[7:6];
            dio_e <= hwdata[5:4];
         end
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) on_cnt <= 10'h000;
      else on_cnt <= led_sink_pin ? on_cnt + 10'h001 : 10'h000;
   end
   a_okay_resp: assert property (hresp == 1'b0 && hreadyout == 1'b1)
      else $error("bus answer not OKAY with zero wait");
   a_sleep_hold: assert property (
      sleeping && !pwr_q && !(wr_en && hwdata[EN_PWR]) |=> sleeping)
      else $error("left sleep without power on");
   a_wake_on_pon: assert property (
      wr_en && hwdata[EN_PWR] && sleeping |-> ##[1:4] !sleeping)
      else $error("power on did not leave sleep");
   a_off_sleep: assert property (
      $fell(adc_busy) && !pwr_q |-> ##[0:3] sleeping)
      else $error("no sleep after finished conversion");
   a_busy_awake: assert property (adc_busy |-> !sleeping)
      else $error("busy while asleep");
   a_led_in_busy: assert property (led_sink_pin |-> adc_busy)
      else $error("led lit outside accumulation");
   a_led_on_len: assert property (
      $fell(led_sink_pin) |-> on_cnt == LED_ON_CYC)
      else $error("led on time wrong");
   a_cfg_follow: assert property (
      cfg_q |-> ##[0:1] (led_current_setting == drv_e &&
                         photodiode_select == dio_e))
      else $error("settings outputs not following config");
   a_unmapped_zero: assert property (rd_adc |-> hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");
endmodule : pss_props
bind pss_sequencer pss_props #(
   .STEP_CYCLES (STEP_CYCLES)
) pss_props_inst (
   .hclk                (hclk),
   .hresetn             (hresetn),
   .hsel                (hsel),
   .haddr               (haddr),
   .htrans              (htrans),
   .hwrite              (hwrite),
   .hwdata              (hwdata),
   .hready              (hready),
   .hrdata              (hrdata),
   .hreadyout           (hreadyout),
   .hresp               (hresp),
   .led_sink_pin        (led_sink_pin),
   .led_current_setting (led_current_setting),
   .photodiode_select   (photodiode_select),
   .adc_busy            (adc_busy),
   .sleeping            (sleeping)
);
`default_nettype wire

// ---- verification/testbench.sv ----
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import pss_pkg::*;
   localparam int SC = 20;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic        led_sink_pin, adc_busy, sleeping;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans, led_current_setting, photodiode_select;
   logic [2:0]  hsize;
   logic [9:0]  adc_sample;
   int          checked, bad_count, pa, pb, pc;
   time         t;
   assign hready = hreadyout;
   pss_sequencer #(.STEP_CYCLES(SC)) pss_sequencer_inst (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .adc_sample(adc_sample), .led_sink_pin(led_sink_pin),
      .led_current_setting(led_current_setting),
      .photodiode_select(photodiode_select), .adc_busy(adc_busy),
      .sleeping(sleeping));
   pss_afe_model pss_afe_model_inst (.hclk(hclk), .adc_busy(adc_busy),
      .adc_sample(adc_sample));
   task close_out;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= HTRANS_NSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask : xfer
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask : wr
   task rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0000_0000, q);
      chk(q, e);
   endtask : rchk
   task till(input logic v);
      for (int i = 0; i < 20000 && adc_busy !== v; i++) @(posedge hclk);
   endtask : till
   // Rise-to-rise of busy, taken after a fresh rise so settings apply
   task period(output int p);
      time t0;
      till(1'b0);
      till(1'b1);
      t0 = $time;
      till(1'b0);
      till(1'b1);
      p = int'(($time - t0) / 20);
   endtask : period
   task t_reset;
      rchk(ADDR_ENABLE, 32'(RST_ENABLE));
      rchk(ADDR_ITIME, 32'(RST_ITIME));
      rchk(ADDR_WTIME, 32'(RST_WTIME));
      rchk(ADDR_PULSE, 32'(RST_PULSE));
      rchk(ADDR_CONFIG, 32'(RST_CONFIG));
      rchk(ADDR_STATUS, 32'h0000_0000);
      rchk(ADDR_ADCIN, 32'h0000_0000);
      chk(32'(sleeping), 32'h0000_0001);
   endtask : t_reset
   task t_idle;
      wr(ADDR_ENABLE, 32'h0000_0001);
      repeat (4) @(posedge hclk);
      rchk(ADDR_STATUS, 32'h0000_0001);
      chk(32'(adc_busy), 32'h0000_0000);
   endtask : t_idle
   task t_prox;
      int  n;
      logic pl;
      n = 0;
      pl = 1'b0;
      wr(ADDR_PULSE, 32'h0000_0002);
      wr(ADDR_ENABLE, 32'h0000_0005);
      till(1'b1);
      for (int i = 0; i < 5000 && adc_busy === 1'b1; i++) begin
         @(posedge hclk);
         if (led_sink_pin === 1'b1 && !pl) n++;
         pl = led_sink_pin;
      end
      chk(n, 2);
      rchk(ADDR_RESULT, 32'h0000_014A);
      till(1'b1);
      chk(32'(adc_busy), 32'h0000_0001);
      wr(ADDR_PULSE, 32'h0000_0000);
      rchk(ADDR_PULSE, 32'h0000_0001);
   endtask : t_prox
   task t_cfg;
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_CONFIG, 32'(i * 16 + (3 - i) * 64));
         repeat (3) @(posedge hclk);
         chk(32'(photodiode_select), i);
         chk(32'(led_current_setting), 3 - i);
      end
   endtask : t_cfg
   task t_wait;
      wr(ADDR_CONFIG, 32'h0000_0000);
      wr(ADDR_WTIME, 32'h0000_00FE);
      period(pa);
      wr(ADDR_ENABLE, 32'h0000_000D);
      period(pb);
      wr(ADDR_CONFIG, 32'h0000_0002);
      period(pc);
      chk(32'(pb - pa >= 2 * SC && pb - pa <= 2 * SC + 2), 1);
      chk(pc - pb, 22 * SC);
   endtask : t_wait
   task t_off;
      wr(ADDR_PULSE, 32'h0000_0002);
      wr(ADDR_ENABLE, 32'h0000_0005);
      till(1'b0);
      till(1'b1);
      t = $time;
      wr(ADDR_ENABLE, 32'h0000_0000);
      till(1'b0);
      chk(32'(($time - t) / 20 >= 2 * PULSE_CYC + SC), 1);
      repeat (4) @(posedge hclk);
      chk(32'(sleeping), 32'h0000_0001);
      repeat (100) @(posedge hclk);
      chk(32'(sleeping), 32'h0000_0001);
   endtask : t_off
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   initial begin
      #2_000_000;
      bad_count++;
      close_out;
   end
   initial begin
      {hsel, hwrite, haddr, hwdata, htrans} = '0;
      hsize = 3'b010;
      hresetn = 1'b0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_idle;
      t_prox;
      t_cfg;
      t_wait;
      t_off;
      close_out;
   end
endmodule : testbench
`default_nettype wire
